/* File: dsl_chk_sva.sv */
// dsl_chk_sva: timing checks on the host-to-converter link
// assumes link signals are sampled on clk, the 100 MHz clock of both ends
`default_nettype none
module dsl_chk_sva #(
	parameter int GAP_RANGE_CYC = dsl_pkg::GAP_RANGE_CYC,
	parameter int RST_WAIT_CYC  = dsl_pkg::RST_WAIT_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic sync_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic load_strobe_n,
	input wire logic reset_n,
	input wire logic sdo
);
	import dsl_pkg::*;
	logic      [5:0]  cnt_q;
	logic      [23:0] word_q;
	logic      [3:0]  rng_q;
	logic             rd_q;
	logic             code_q;
	logic             chg_q;
	logic      [19:0] hi_q;
	logic      [19:0] lo_q;
	logic      [19:0] rhi_q;
	logic      [19:0] rlo_q;
	wire logic [4:0]  addr = word_q[ADDR_LSB +: ADDR_W];
	wire logic        wr = !word_q[RW_BIT];

	always_ff @(posedge clk) begin
		if (reset_n == 1'h0)
			rlo_q <= rlo_q + 20'h1;
		else
			rlo_q <= '0;
		if (srst) begin
			cnt_q  <= '0;
			rd_q   <= 1'h0;
			code_q <= 1'h0;
			chg_q  <= 1'h0;
			rng_q  <= '0;
			hi_q   <= '0;
			lo_q   <= '0;
			rhi_q  <= '0;
		end else begin
			hi_q  <= sync_n ? hi_q + 20'h1 : '0;
			lo_q  <= load_strobe_n ? '0 : lo_q + 20'h1;
			rhi_q <= reset_n ? rhi_q + 20'h1 : '0;
			if (sync_n) begin
				cnt_q <= '0;
				rd_q  <= 1'h0;
			end else if ($fell(sclk)) begin
				cnt_q  <= cnt_q + 6'h1;
				word_q <= (cnt_q < 6'h18) ? {word_q[22:0], sdi} : word_q;
				rd_q   <= (cnt_q == 6'h0) ? sdi : rd_q;
			end
			if ($rose(sync_n)) begin
				code_q <= wr && addr == ADDR_CODE;
				chg_q  <= wr && addr == ADDR_SETUP && word_q[3:0] != rng_q;
				rng_q  <= (wr && addr == ADDR_SETUP) ? word_q[3:0] : rng_q;
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	sequence s_open;
		$fell(sync_n);
	endsequence
	sequence s_rd_half;
		sclk [*6];
	endsequence

	chk_frame_end: assert property ($rose(sync_n) |-> (cnt_q == 6'h18 || cnt_q == 6'h20) && !$past(sclk))
		else $error("frame closed with bad bit count");
	chk_gap_plain: assert property (s_open |-> hi_q >= GAP_WR_CYC)
		else $error("select gap too short");
	chk_gap_code: assert property (s_open ##0 code_q |-> hi_q >= GAP_CODE_CYC)
		else $error("gap after code write too short");
	chk_gap_range: assert property (s_open ##0 chg_q |-> hi_q >= GAP_RANGE_CYC)
		else $error("gap after range change too short");
	chk_load_frame: assert property (!load_strobe_n |-> sync_n)
		else $error("load low inside a frame");
	chk_load_after: assert property ($fell(load_strobe_n) |-> hi_q >= LOAD_AFTER_CYC)
		else $error("load too soon after select rise");
	chk_load_width: assert property ($rose(load_strobe_n) |-> lo_q >= LOAD_LOW_CYC)
		else $error("load pulse too short");
	chk_reset_width: assert property ($rose(reset_n) |-> rlo_q >= RST_LOW_CYC)
		else $error("reset pulse too short");
	chk_reset_wait: assert property ($rose(sclk) |-> rhi_q >= RST_WAIT_CYC)
		else $error("clock too soon after reset");
	chk_sdo_launch: assert property (!sync_n && !$past(sync_n) && !$stable(sdo) |-> sclk)
		else $error("readback bit moved off a rise");
	chk_read_clock: assert property (!sync_n && rd_q && $rose(sclk) |-> s_rd_half)
		else $error("read clock high phase too short");
endmodule
`default_nettype wire

/* File: dsl_dev.sv */
// dsl_dev: converter end of the link; shift logic on the link clock, registers on clk
// assumes host keeps sclk idle low, frames framed by sync_n, data sampled on sclk fall
`default_nettype none
module dsl_dev (
	input  wire logic                        clk,
	input  wire logic                        srst,
	input  wire logic                        crc_en,
	output logic      [dsl_pkg::DATA_W-1:0]  dac_out,
	output logic                             dac_update,
	output logic      [dsl_pkg::RANGE_W-1:0] out_range,
	output logic                             slew_en,
	dsl_if.dev                               lnk
);
	import dsl_pkg::*;

	logic [BC_W-1:0]   icnt_q, icnt_d, ocnt_q, ocnt_d, nb;
	logic [31:0]       ish_q, ish_d;
	logic [HDR_W-1:0]  hdr_q, hdr_d;
	logic [23:0]       word_q, word_d;
	logic              tgl_q, tgl_d, done, sdo_q, sdo_d;
	logic [DATA_W-1:0] rdval;

	assign nb = crc_en ? BC_W'(BITS_CRC) : BC_W'(BITS_STD);

	// input shifter, cleared whenever the frame select is high
	always_comb begin
		ish_d  = {ish_q[30:0], lnk.sdi};
		icnt_d = (icnt_q == nb) ? icnt_q : icnt_q + 1'b1;
		hdr_d  = (icnt_q == BC_W'(HDR_W - 1)) ? ish_d[HDR_W-1:0] : hdr_q;
		done   = (icnt_q == nb - 1'b1);
		word_d = done ? (crc_en ? ish_d[31:8] : ish_d[23:0]) : word_q;
		tgl_d  = tgl_q ^ done;
	end

	always_ff @(negedge lnk.sclk or posedge lnk.sync_n) begin
		if (lnk.sync_n) begin
			icnt_q <= '0;
			ish_q  <= '0;
			hdr_q  <= '0;
		end else begin
			icnt_q <= icnt_d;
			ish_q  <= ish_d;
			hdr_q  <= hdr_d;
		end
	end

	always_ff @(negedge lnk.sclk or negedge lnk.reset_n) begin
		if (!lnk.reset_n) begin
			word_q <= '0;
			tgl_q  <= 1'b0;
		end else begin
			word_q <= word_d;
			tgl_q  <= tgl_d;
		end
	end

	// readback: bits launched on each sclk rise, zero outside the data field
	logic [DATA_W-1:0] code_q, setup_q;
	always_comb begin
		rdval  = (hdr_q[ADDR_W-1:0] == ADDR_CODE) ? code_q :
			(hdr_q[ADDR_W-1:0] == ADDR_SETUP) ? setup_q : '0;
		ocnt_d = (ocnt_q == BC_W'(BITS_CRC)) ? ocnt_q : ocnt_q + 1'b1;
		sdo_d  = 1'b0;
		if (hdr_q[HDR_W-1] && ocnt_q >= BC_W'(HDR_W) && ocnt_q < BC_W'(BITS_STD)) begin
			sdo_d = rdval[4'(BC_W'(BITS_STD - 1) - ocnt_q)];
		end
	end

	always_ff @(posedge lnk.sclk or posedge lnk.sync_n) begin
		if (lnk.sync_n) begin
			ocnt_q <= '0;
			sdo_q  <= 1'b0;
		end else begin
			ocnt_q <= ocnt_d;
			sdo_q  <= sdo_d;
		end
	end

	assign lnk.sdo    = sdo_q;
	assign lnk.sdo_oe = !lnk.sync_n;

	// register side on clk
	logic rstn_s, ld_s, tgl_s, ld_prev_q, ld_prev_d, tgl_prev_q, tgl_prev_d;
	logic [DATA_W-1:0] code_d, setup_d, out_q, out_d;
	logic upd_q, upd_d, wr, wr_code;

	dsl_sync #(.W(3), .INIT(3'h6)) u_sync (
		.clk  (clk),
		.srst (srst),
		.d    ({lnk.reset_n, lnk.load_strobe_n, tgl_q}),
		.q    ({rstn_s, ld_s, tgl_s})
	);

	always_comb begin
		wr         = (tgl_s ^ tgl_prev_q) && !word_q[RW_BIT];
		wr_code    = wr && (word_q[ADDR_LSB +: ADDR_W] == ADDR_CODE);
		code_d     = wr_code ? word_q[DATA_W-1:0] : code_q;
		setup_d    = (wr && word_q[ADDR_LSB +: ADDR_W] == ADDR_SETUP) ? word_q[DATA_W-1:0] : setup_q;
		ld_prev_d  = ld_s;
		tgl_prev_d = tgl_s;
		upd_d      = 1'b0;
		out_d      = out_q;
		if (ld_prev_q && !ld_s) begin
			upd_d = 1'b1;
			out_d = code_d;
		end else if (wr_code && !ld_s) begin
			upd_d = 1'b1;
			out_d = code_d;
		end
		if (!rstn_s) begin
			code_d  = CODE_RST;
			setup_d = SETUP_RST;
			out_d   = CODE_RST;
			upd_d   = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			code_q     <= CODE_RST;
			setup_q    <= SETUP_RST;
			out_q      <= CODE_RST;
			upd_q      <= 1'b0;
			ld_prev_q  <= 1'b1;
			tgl_prev_q <= 1'b0;
		end else begin
			code_q     <= code_d;
			setup_q    <= setup_d;
			out_q      <= out_d;
			upd_q      <= upd_d;
			ld_prev_q  <= ld_prev_d;
			tgl_prev_q <= tgl_prev_d;
		end
	end

	assign dac_out    = out_q;
	assign dac_update = upd_q;
	assign out_range  = setup_q[RANGE_W-1:0];
	assign slew_en    = setup_q[SLEW_BIT];
endmodule
`default_nettype wire

/* File: dsl_host.sv */
// dsl_host: controller end; makes sclk by dividing clk, paces frames, load pulses and reset
// assumes the converter end samples sdi on sclk fall and launches sdo on sclk rise
`default_nettype none
module dsl_host #(
	parameter int GAP_RANGE_CYC = dsl_pkg::GAP_RANGE_CYC,
	parameter int RST_WAIT_CYC  = dsl_pkg::RST_WAIT_CYC,
	parameter int WR_HALF       = dsl_pkg::WR_HALF_CYC,
	parameter int RD_HALF       = dsl_pkg::RD_HALF_CYC
) (
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire logic                       crc_en,
	input  wire logic                       req_valid,
	output logic                            req_ready,
	input  wire logic                       req_read,
	input  wire logic [dsl_pkg::ADDR_W-1:0] req_addr,
	input  wire logic [dsl_pkg::DATA_W-1:0] req_data,
	input  wire logic                       load_valid,
	output logic                            load_ready,
	output logic                            rsp_valid,
	output logic      [dsl_pkg::DATA_W-1:0] rsp_data,
	output logic                            link_ready,
	dsl_if.host                             lnk
);
	import dsl_pkg::*;

	typedef enum logic [5:0] {
		S_RSTL  = 6'h01,
		S_RSTW  = 6'h02,
		S_IDLE  = 6'h04,
		S_SHIFT = 6'h08,
		S_TAIL  = 6'h10,
		S_LOAD  = 6'h20
	} dsl_state_t;

	localparam logic [CNT_W-1:0] C_MAX   = '1;
	localparam logic [CNT_W-1:0] C_RSTL  = CNT_W'(RST_LOW_CYC - 1);
	localparam logic [CNT_W-1:0] C_RSTW  = CNT_W'(RST_WAIT_CYC - 1);
	localparam logic [CNT_W-1:0] C_END   = CNT_W'(END_CYC - 1);
	localparam logic [CNT_W-1:0] C_LLOW  = CNT_W'(LOAD_LOW_CYC - 1);
	localparam logic [CNT_W-1:0] C_LAFT  = CNT_W'(LOAD_AFTER_CYC);
	localparam logic [CNT_W-1:0] C_GWR   = CNT_W'(GAP_WR_CYC);
	localparam logic [CNT_W-1:0] C_GCODE = CNT_W'(GAP_CODE_CYC);
	localparam logic [CNT_W-1:0] C_GRNG  = CNT_W'(GAP_RANGE_CYC);

	dsl_state_t         st_q, st_d;
	logic [CNT_W-1:0]   cnt_q, cnt_d, el_q, el_d, gap_q, gap_d, half;
	logic [BC_W-1:0]    bc_q, bc_d, nb;
	logic [31:0]        sh_q, sh_d, rx_q, rx_d;
	logic [RANGE_W-1:0] range_q, range_d;
	logic               rd_q, rd_d, wide_q, wide_d;
	logic               sclk_q, sclk_d, sync_n_q, sync_n_d, sdi_q, sdi_d;
	logic               ld_n_q, ld_n_d, rstn_q, rstn_d;
	logic               rsp_v_q, rsp_v_d;
	logic [DATA_W-1:0]  rsp_q, rsp_d;
	logic               sdo_s;

	dsl_sync #(.W(1), .INIT(1'b0)) u_sdo (
		.clk  (clk),
		.srst (srst),
		.d    (lnk.sdo_line),
		.q    (sdo_s)
	);

	assign half = rd_q ? CNT_W'(RD_HALF) : CNT_W'(WR_HALF);
	assign nb   = wide_q ? BC_W'(BITS_CRC) : BC_W'(BITS_STD);

	always_comb begin
		st_d       = st_q;
		cnt_d      = cnt_q;
		el_d       = (el_q == C_MAX) ? el_q : el_q + 1'b1;
		gap_d      = gap_q;
		bc_d       = bc_q;
		sh_d       = sh_q;
		rx_d       = rx_q;
		range_d    = range_q;
		rd_d       = rd_q;
		wide_d     = wide_q;
		sclk_d     = sclk_q;
		sync_n_d   = sync_n_q;
		sdi_d      = sdi_q;
		ld_n_d     = ld_n_q;
		rstn_d     = rstn_q;
		rsp_v_d    = 1'b0;
		rsp_d      = rsp_q;
		req_ready  = 1'b0;
		load_ready = 1'b0;
		unique case (st_q)
			S_RSTL: begin
				rstn_d = 1'b0;
				cnt_d  = cnt_q + 1'b1;
				if (cnt_q == C_RSTL) begin
					rstn_d = 1'b1;
					cnt_d  = '0;
					st_d   = S_RSTW;
				end
			end
			S_RSTW: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == C_RSTW) begin
					el_d = C_MAX;
					st_d = S_IDLE;
				end
			end
			S_IDLE: begin
				// load only between frames, never inside one
				load_ready = (el_q >= C_LAFT);
				req_ready  = (el_q >= gap_q) && !load_valid;
				if (load_valid && load_ready) begin
					ld_n_d = 1'b0;
					cnt_d  = '0;
					st_d   = S_LOAD;
				end else if (req_valid && req_ready) begin
					sh_d     = {req_read, 2'b00, req_addr, req_data, 8'h00};
					rd_d     = req_read;
					wide_d   = crc_en;
					sync_n_d = 1'b0;
					sclk_d   = 1'b0;
					cnt_d    = '0;
					bc_d     = '0;
					rx_d     = '0;
					gap_d    = C_GWR;
					if (!req_read && req_addr == ADDR_CODE) begin
						gap_d = C_GCODE;
					end
					if (!req_read && req_addr == ADDR_SETUP) begin
						range_d = req_data[RANGE_W-1:0];
						if (req_data[RANGE_W-1:0] != range_q) begin
							gap_d = C_GRNG;
						end
					end
					st_d = S_SHIFT;
				end
			end
			S_LOAD: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == C_LLOW) begin
					ld_n_d = 1'b1;
					st_d   = S_IDLE;
				end
			end
			S_SHIFT: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == half - 1'b1) begin
					cnt_d  = '0;
					sclk_d = !sclk_q;
					if (!sclk_q) begin
						sdi_d = sh_q[31];
						sh_d  = {sh_q[30:0], 1'b0};
					end else begin
						rx_d = {rx_q[30:0], sdo_s};
						bc_d = bc_q + 1'b1;
						if (bc_q == nb - 1'b1) begin
							st_d = S_TAIL;
						end
					end
				end
			end
			S_TAIL: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == C_END) begin
					sync_n_d = 1'b1;
					el_d     = '0;
					rsp_v_d  = rd_q;
					rsp_d    = wide_q ? rx_q[23:8] : rx_q[DATA_W-1:0];
					st_d     = S_IDLE;
				end
			end
			default: begin
				st_d = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_q     <= S_RSTL;
			cnt_q    <= '0;
			el_q     <= '0;
			gap_q    <= '0;
			bc_q     <= '0;
			sh_q     <= '0;
			rx_q     <= '0;
			range_q  <= SETUP_RST[RANGE_W-1:0];
			rd_q     <= 1'b0;
			wide_q   <= 1'b0;
			sclk_q   <= 1'b0;
			sync_n_q <= 1'b1;
			sdi_q    <= 1'b0;
			ld_n_q   <= 1'b1;
			rstn_q   <= 1'b0;
			rsp_v_q  <= 1'b0;
			rsp_q    <= '0;
		end else begin
			st_q     <= st_d;
			cnt_q    <= cnt_d;
			el_q     <= el_d;
			gap_q    <= gap_d;
			bc_q     <= bc_d;
			sh_q     <= sh_d;
			rx_q     <= rx_d;
			range_q  <= range_d;
			rd_q     <= rd_d;
			wide_q   <= wide_d;
			sclk_q   <= sclk_d;
			sync_n_q <= sync_n_d;
			sdi_q    <= sdi_d;
			ld_n_q   <= ld_n_d;
			rstn_q   <= rstn_d;
			rsp_v_q  <= rsp_v_d;
			rsp_q    <= rsp_d;
		end
	end

	assign lnk.sclk          = sclk_q;
	assign lnk.sync_n        = sync_n_q;
	assign lnk.sdi           = sdi_q;
	assign lnk.load_strobe_n = ld_n_q;
	assign lnk.reset_n       = rstn_q;
	assign rsp_valid         = rsp_v_q;
	assign rsp_data          = rsp_q;
	assign link_ready        = (st_q != S_RSTL) && (st_q != S_RSTW);
endmodule
`default_nettype wire

/* File: dsl_if.sv */
// dsl_if: serial link between host and converter
// sdo_line resolves the device's output enable; undriven line reads low
`default_nettype none
interface dsl_if;
	logic sync_n;
	logic sclk;
	logic sdi;
	logic load_strobe_n;
	logic reset_n;
	logic sdo;
	logic sdo_oe;
	logic sdo_line;

	assign sdo_line = sdo_oe ? sdo : 1'b0;

	modport dev (
		input  sync_n,
		input  sclk,
		input  sdi,
		input  load_strobe_n,
		input  reset_n,
		output sdo,
		output sdo_oe
	);

	modport host (
		output sync_n,
		output sclk,
		output sdi,
		output load_strobe_n,
		output reset_n,
		input  sdo_line
	);
endinterface
`default_nettype wire

/* File: dsl_pkg.sv */
// dsl_pkg: shared constants for the serial load link (frame layout, addresses, timing counts)
// assumes a 100 MHz system clock on both ends
`default_nettype none
package dsl_pkg;
	localparam int CLK_NS     = 10;
	localparam int BITS_STD   = 24;
	localparam int BITS_CRC   = 32;
	localparam int CNT_W      = 17;
	localparam int BC_W       = 6;
	// frame layout: {rd, 2'b00, addr[4:0], data[15:0]}, checksum byte follows when enabled
	localparam int RW_BIT     = 23;
	localparam int ADDR_LSB   = 16;
	localparam int ADDR_W     = 5;
	localparam int DATA_W     = 16;
	localparam int HDR_W      = 8;
	localparam int RANGE_W    = 4;
	localparam int SLEW_BIT   = 4;
	localparam logic [ADDR_W-1:0] ADDR_NOP   = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_CODE  = 5'h01;
	localparam logic [ADDR_W-1:0] ADDR_SETUP = 5'h02;
	localparam logic [DATA_W-1:0] CODE_RST   = 16'h0000;
	localparam logic [DATA_W-1:0] SETUP_RST  = 16'h0000;
	// times in ns
	localparam int T_END_NS        = 10;
	localparam int T_GAP_WR_NS     = 500;
	localparam int T_GAP_CODE_NS   = 1500;
	localparam int T_GAP_RANGE_NS  = 500000;
	localparam int T_LOAD_FRAME_NS = 750;
	localparam int T_LOAD_AFTER_NS = 1500;
	localparam int T_LOAD_LOW_NS   = 250;
	localparam int T_RESP_NS       = 600;
	localparam int T_RESP_SLEW_NS  = 2000;
	localparam int T_RESP_HELD_NS  = 1500;
	localparam int T_RST_LOW_NS    = 5000;
	localparam int T_RST_WAIT_NS   = 100000;
	localparam int T_WR_CYC_NS     = 33;
	localparam int T_RD_CYC_NS     = 120;

	function automatic int cyc_min(input int ns);
		int r;
		r = (ns + CLK_NS - 1) / CLK_NS;
		return (r < 1) ? 1 : r;
	endfunction

	function automatic int cyc_max(input int ns);
		int r;
		r = ns / CLK_NS;
		return (r < 1) ? 1 : r;
	endfunction

	localparam int END_CYC        = cyc_min(T_END_NS);
	localparam int GAP_WR_CYC     = cyc_min(T_GAP_WR_NS);
	localparam int GAP_CODE_CYC   = cyc_min(T_GAP_CODE_NS);
	localparam int GAP_RANGE_CYC  = cyc_min(T_GAP_RANGE_NS);
	localparam int LOAD_FRAME_CYC = cyc_min(T_LOAD_FRAME_NS);
	localparam int LOAD_AFTER_CYC = cyc_min(T_LOAD_AFTER_NS);
	localparam int LOAD_LOW_CYC   = cyc_min(T_LOAD_LOW_NS);
	localparam int RESP_CYC       = cyc_max(T_RESP_NS);
	localparam int RESP_SLEW_CYC  = cyc_max(T_RESP_SLEW_NS);
	localparam int RESP_HELD_CYC  = cyc_max(T_RESP_HELD_NS);
	localparam int RST_LOW_CYC    = cyc_min(T_RST_LOW_NS);
	localparam int RST_WAIT_CYC   = cyc_min(T_RST_WAIT_NS);
	localparam int WR_HALF_CYC    = (cyc_min(T_WR_CYC_NS) + 1) / 2;
	localparam int RD_HALF_CYC    = (cyc_min(T_RD_CYC_NS) + 1) / 2;
endpackage
`default_nettype wire

/* File: dsl_sync.sv */
// dsl_sync: two-flop synchroniser with a chosen reset level
// assumes d is asynchronous to clk; q is safe to use in clk domain
`default_nettype none
module dsl_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] m_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			m_q <= INIT;
			q   <= INIT;
		end else begin
			m_q <= d;
			q   <= m_q;
		end
	end
endmodule
`default_nettype wire

/* File: test_dac_serial_load_timing.sv */
// test_dac_serial_load_timing: host and converter joined by dsl_if, plus a lone converter end
// assumes dsl_pkg constants; host and checker range-change gap and reset wait counts shortened
`default_nettype none
module test_dac_serial_load_timing;
	timeunit 1ns;
	timeprecision 100ps;
	import dsl_pkg::*;
	localparam int GAP_R = 200;
	localparam int RST_W = 20;
	logic        clk = 1'h0, srst = 1'h1, crc_en = 1'h0, req_valid = 1'h0, req_read = 1'h0, load_valid = 1'h0;
	logic [4:0]  req_addr = '0;
	logic [15:0] req_data = '0, code_e = '0, setup_e = '0, rsp_data, dac_out, dac_out_b;
	logic [3:0]  out_range;
	logic        req_ready, load_ready, link_ready, dac_update, slew_en, rsp_valid, dac_update_b;
	logic [31:0] seed = 32'h78BC;
	int          n_fail = 0, checks = 0, n_load = 0, n_upd = 0, n_rsp = 0, n_rd = 0;

	dsl_if i_dsl_if ();
	dsl_if i_dsl_if_b ();
	dsl_host #(.GAP_RANGE_CYC(GAP_R), .RST_WAIT_CYC(RST_W)) i_dsl_host (.clk(clk), .srst(srst), .crc_en(crc_en),
		.req_valid(req_valid), .req_ready(req_ready), .req_read(req_read), .req_addr(req_addr), .req_data(req_data),
		.load_valid(load_valid), .load_ready(load_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.link_ready(link_ready), .lnk(i_dsl_if.host));
	dsl_dev i_dsl_dev (.clk(clk), .srst(srst), .crc_en(crc_en), .dac_out(dac_out), .dac_update(dac_update),
		.out_range(out_range), .slew_en(slew_en), .lnk(i_dsl_if.dev));
	dsl_dev i_dsl_dev_b (.clk(clk), .srst(srst), .crc_en(1'h0), .dac_out(dac_out_b),
		.dac_update(dac_update_b), .out_range(), .slew_en(), .lnk(i_dsl_if_b.dev));
	dsl_chk_sva #(.GAP_RANGE_CYC(GAP_R), .RST_WAIT_CYC(RST_W)) i_dsl_chk_sva (.clk(clk), .srst(srst),
		.sync_n(i_dsl_if.sync_n), .sclk(i_dsl_if.sclk), .sdi(i_dsl_if.sdi),
		.load_strobe_n(i_dsl_if.load_strobe_n), .reset_n(i_dsl_if.reset_n), .sdo(i_dsl_if.sdo));

	always #5 clk = ~clk;
	always @(negedge clk) begin
		if (dac_update === 1'h1)
			n_upd++;
		if (rsp_valid === 1'h1)
			n_rsp++;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] reg_val(input logic [4:0] a);
		return (a == ADDR_CODE) ? code_e : setup_e;
	endfunction

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic boot();
		int n;
		@(negedge clk);
		srst = 1'h1;
		repeat (20) @(negedge clk);
		srst = 1'h0;
		code_e = CODE_RST;
		setup_e = SETUP_RST;
		n = 0;
		while (link_ready !== 1'h1 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		chk("reset wait", 16'h1, {15'h0, n >= RST_LOW_CYC + RST_W && n < 1000});
		chk("output after reset", CODE_RST, dac_out);
		$display("reset done");
	endtask

	task automatic req(input logic rd, input logic [4:0] a, input logic [15:0] d);
		int n;
		@(negedge clk);
		req_valid = 1'h1;
		req_read = rd;
		req_addr = a;
		req_data = d;
		n = 0;
		while (req_ready !== 1'h1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk("request taken", 16'h1, {15'h0, n < 2000});
		@(negedge clk);
		req_valid = 1'h0;
		if (!rd && a == ADDR_CODE)
			code_e = d;
		if (!rd && a == ADDR_SETUP)
			setup_e = d;
		if (rd)
			n_rd++;
		n = 0;
		while (i_dsl_if.sync_n !== 1'h1 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		chk("frame closed", 16'h1, {15'h0, n < 1000});
		repeat (8) @(negedge clk);
		chk("setup outputs", {11'h0, setup_e[4:0]}, {11'h0, slew_en, out_range});
		if (rd)
			chk("readback", reg_val(a), rsp_data);
	endtask

	task automatic load();
		int n;
		@(negedge clk);
		load_valid = 1'h1;
		n = 0;
		while (load_ready !== 1'h1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk("load taken", 16'h1, {15'h0, n < 2000});
		@(negedge clk);
		load_valid = 1'h0;
		n_load++;
		n = 0;
		while (dac_update !== 1'h1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk("response", 16'h1, {15'h0, n <= (setup_e[SLEW_BIT] ? RESP_SLEW_CYC : RESP_CYC)});
		chk("output", code_e, dac_out);
	endtask

	task automatic frame_b(input logic [23:0] w, input int nb, input int h, output logic [31:0] got);
		got = '0;
		i_dsl_if_b.sync_n = 1'h0;
		for (int k = 0; k < nb; k++) begin
			#(h) i_dsl_if_b.sclk = 1'h1;
			i_dsl_if_b.sdi = (k < 24) ? w[23 - k] : 1'h0;
			#(h) got = {got[30:0], i_dsl_if_b.sdo_line};
			i_dsl_if_b.sclk = 1'h0;
		end
		#10 i_dsl_if_b.sync_n = 1'h1;
		i_dsl_if_b.sdi = ~i_dsl_if_b.sdi;
	endtask

	// select rise and reset pulse clear the lone end's link flops
	initial begin
		i_dsl_if_b.sync_n = 1'h0;
		i_dsl_if_b.sclk = 1'h0;
		i_dsl_if_b.sdi = 1'h0;
		i_dsl_if_b.load_strobe_n = 1'h1;
		i_dsl_if_b.reset_n = 1'h1;
		@(negedge clk);
		i_dsl_if_b.sync_n = 1'h1;
		i_dsl_if_b.reset_n = 1'h0;
		repeat (RST_LOW_CYC) @(negedge clk);
		i_dsl_if_b.reset_n = 1'h1;
	end

	initial begin
		#(60000 * 10);
		n_fail++;
		$display("[ERR] watchdog expected finish seen timeout");
		stop_test();
	end

	initial begin
		logic [31:0] got;
		int          n;
		boot();
		req(1'h0, ADDR_SETUP, 16'h0015);
		req(1'h0, ADDR_CODE, 16'hFFFF);
		load();
		req(1'h0, ADDR_NOP, 16'h1234);
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			crc_en = seed[8];
			req(1'h0, seed[0] ? ADDR_CODE : ADDR_SETUP, seed[31:16]);
			req(1'h1, ADDR_CODE, 16'h0);
			req(1'h1, ADDR_SETUP, 16'h0);
			load();
			$display("random step %0d done", i);
		end
		i_dsl_if_b.load_strobe_n = 1'h0;
		repeat (8) @(negedge clk);
		frame_b({3'h0, ADDR_CODE, 16'hA5C3}, 24, 3, got);
		n = 0;
		while (dac_update_b !== 1'h1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		chk("held load response", 16'h1, {15'h0, n <= RESP_HELD_CYC});
		chk("held load output", 16'hA5C3, dac_out_b);
		repeat (GAP_R) @(negedge clk);
		frame_b({3'h0, ADDR_SETUP, 16'h001F}, 24, 3, got);
		repeat (GAP_R) @(negedge clk);
		frame_b({3'h4, ADDR_SETUP, 16'h0000}, 28, 60, got);
		chk("lone readback", 16'h001F, got[19:4]);
		chk("extra bits", 16'h0, {12'h0, got[3:0]});
		$display("extra clock test done");
		boot();
		req(1'h1, ADDR_CODE, 16'h0);
		chk("update count", n_load[15:0], n_upd[15:0]);
		chk("read count", n_rd[15:0], n_rsp[15:0]);
		stop_test();
	end
endmodule
`default_nettype wire
